/* File: hdl/ledc_config_regs.sv */
`timescale 1ns/1ps
`include "ledc_consts.svh"

// Operation
// [RULE1] Top twelve bits: self-test, adjacent check, reset
// [RULE2] Command codes select status, config, grayscale readback
// [RULE3] Codes toggle negate bit, clear latched errors
// [RULE4] Fault mask resets set; zero reports errors
// [RULE5] Sink bit selects 20 or 40 uA
// [RULE6] Act only on full latched word; others ignored
// [RULE7] Width field picks 12, 10, 8-bit counter
// [RULE8] Eight-bit brightness per colour, reset zero
// [RULE9] One range bit per colour group
module ledc_config_regs
  import ledc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  // Register port
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  // Fault report from the output stage
  input  wire logic              i_led_error,
  // Command actions
  output logic                   o_global_reset,
  output logic                   o_selftest_start,
  output logic                   o_aps_start,
  output logic                   o_error_clear,
  output logic                   o_negate_check_bit,
  output ledc_rb_sel_t           o_readback_sel,
  output logic                   o_led_error_flag,
  // Decoded settings and interrupt
  output ledc_cfg_t              o_cfg,
  output logic                   o_irq
);

  localparam int                   TOP_BASE = `LEDC_CFG_BITS - `LEDC_CHUNK_BITS;
  localparam logic [`LEDC_CFG_BITS-1:0] CFG_RST = `LEDC_CFG_BITS'(1) << `LEDC_MASK_BIT;

  logic [`LEDC_CFG_BITS-1:0] stage_q;
  logic [`LEDC_CFG_BITS-1:0] cfg_q;
  logic                      commit_q;
  logic [11:0]               cmd;
  logic                      wr_cfg;
  logic                      wr_top;
  logic [3:0]                chunk;
  logic                      hit_glb;
  logic                      hit_st;
  logic                      hit_aps;
  logic                      hit_neg;
  logic                      hit_clr;
  logic                      err_set;
  logic                      err_q;
  logic [`LEDC_IRQ_N-1:0]    ev;
  logic [`LEDC_IRQ_N-1:0]    stat_q;
  logic [`LEDC_IRQ_N-1:0]    en_q;
  logic                      clr_wr;

  // Address decode of the configuration chunks
  assign chunk  = i_addr[3:0];
  assign wr_cfg = i_wr && (i_addr <= ADDR_W'(`LEDC_CFG_TOP));
  assign wr_top = i_wr && (i_addr == ADDR_W'(`LEDC_CFG_TOP));
  assign clr_wr = i_wr && (i_addr == ADDR_W'(`LEDC_INT_CLR));

  // Command decode only on the cycle after the top chunk lands
  assign cmd     = cfg_q[`LEDC_CMD_MSB:`LEDC_CMD_LSB];
  assign hit_glb = commit_q && (cmd == `LEDC_CMD_GLB_RST);  // [RULE1] [RULE6]
  assign hit_st  = commit_q && (cmd == `LEDC_CMD_SELFTST);  // [RULE1]
  assign hit_aps = commit_q && (cmd == `LEDC_CMD_APS);      // [RULE1]
  assign hit_neg = commit_q && (cmd == `LEDC_CMD_NEGATE);   // [RULE3]
  assign hit_clr = commit_q && (cmd == `LEDC_CMD_ERR_CLR);  // [RULE3]

  // Staging copy; lower chunks take no effect until the top one is written
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stage_q <= CFG_RST;
    end else if (hit_glb) begin
      stage_q <= CFG_RST;
    end else if (wr_cfg) begin
      stage_q[int'(chunk)*`LEDC_CHUNK_BITS +: `LEDC_CHUNK_BITS] <= i_wdata;  // [RULE6]
    end
  end

  // Live word; the top chunk carries the command so it closes the word
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_q    <= CFG_RST;                                     // [RULE4] [RULE5] [RULE8]
      commit_q <= 1'b0;
    end else begin
      commit_q <= wr_top && !hit_glb;
      if (hit_glb) begin
        cfg_q <= CFG_RST;                                      // [RULE1]
      end else if (wr_top) begin
        cfg_q <= {i_wdata, stage_q[`LEDC_CFG_BITS-`LEDC_CHUNK_BITS-1:0]};  // [RULE6]
      end
    end
  end

  // One-cycle command pulses, registered so they are glitch free
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_global_reset   <= 1'b0;
      o_selftest_start <= 1'b0;
      o_aps_start      <= 1'b0;
      o_error_clear    <= 1'b0;
    end else begin
      o_global_reset   <= hit_glb;                             // [RULE1]
      o_selftest_start <= hit_st;                              // [RULE1]
      o_aps_start      <= hit_aps;                             // [RULE1]
      o_error_clear    <= hit_clr;                             // [RULE3]
    end
  end

  // Negate bit flips on its code; a global reset returns it to zero
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_negate_check_bit <= 1'b0;
    end else if (hit_glb) begin
      o_negate_check_bit <= 1'b0;
    end else if (hit_neg) begin
      o_negate_check_bit <= ~o_negate_check_bit;               // [RULE3]
    end
  end

  // Readback choice holds until another readback code or a reset
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_readback_sel <= LEDC_RB_NONE;
    end else if (hit_glb) begin
      o_readback_sel <= LEDC_RB_NONE;
    end else if (commit_q) begin
      unique case (cmd)
        `LEDC_CMD_RD_STAT: o_readback_sel <= LEDC_RB_STAT;     // [RULE2]
        `LEDC_CMD_RD_CFG:  o_readback_sel <= LEDC_RB_CFG;      // [RULE2]
        `LEDC_CMD_RD_GS:   o_readback_sel <= LEDC_RB_GS;       // [RULE2]
        default:           o_readback_sel <= o_readback_sel;   // [RULE6]
      endcase
    end
  end

  // Latched LED error; a new error beats a clear in the same cycle
  assign err_set = i_led_error && !cfg_q[`LEDC_MASK_BIT];      // [RULE4]
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      err_q <= 1'b0;
    end else begin
      err_q <= err_set || (err_q && !hit_clr && !hit_glb);     // [RULE3]
    end
  end
  assign o_led_error_flag = err_q;

  // Counter width from the two-bit field
  function automatic logic [3:0] gs_width(input logic [1:0] sel);
    unique case (sel)
      `LEDC_GSW_SEL10: gs_width = `LEDC_GSW_10;
      `LEDC_GSW_SEL8:  gs_width = `LEDC_GSW_8;
      default:         gs_width = `LEDC_GSW_12;
    endcase
  endfunction

  // Settings straight from the live word flops
  always_comb begin
    o_cfg.blue_group_brightness   = cfg_q[`LEDC_BR_B_MSB:`LEDC_BR_B_LSB];  // [RULE8]
    o_cfg.green_group_brightness  = cfg_q[`LEDC_BR_G_MSB:`LEDC_BR_G_LSB];  // [RULE8]
    o_cfg.red_group_brightness    = cfg_q[`LEDC_BR_R_MSB:`LEDC_BR_R_LSB];  // [RULE8]
    o_cfg.blue_correction_range   = cfg_q[`LEDC_RNG_B_BIT];                // [RULE9]
    o_cfg.green_correction_range  = cfg_q[`LEDC_RNG_G_BIT];                // [RULE9]
    o_cfg.red_correction_range    = cfg_q[`LEDC_RNG_R_BIT];                // [RULE9]
    o_cfg.grayscale_counter_width = gs_width(cfg_q[`LEDC_GSW_MSB:`LEDC_GSW_LSB]);  // [RULE7]
    o_cfg.led_fault_mask          = cfg_q[`LEDC_MASK_BIT];                 // [RULE4]
    o_cfg.adjacent_pin_test_sink  = cfg_q[`LEDC_SINK_BIT];                 // [RULE5]
  end

  // Interrupt events
  assign ev[`LEDC_EV_COMMIT]  = commit_q;
  assign ev[`LEDC_EV_SELFTST] = hit_st;
  assign ev[`LEDC_EV_APS]     = hit_aps;
  assign ev[`LEDC_EV_GLB_RST] = hit_glb;
  assign ev[`LEDC_EV_NEGATE]  = hit_neg;
  assign ev[`LEDC_EV_ERR_CLR] = hit_clr;
  assign ev[`LEDC_EV_LED_ERR] = err_set;

  // Sticky status per bit; set wins so no event is lost to a clear
  for (genvar g = 0; g < `LEDC_IRQ_N; g++) begin : g_stat
    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        stat_q[g] <= 1'b0;
      end else begin
        stat_q[g] <= ev[g] || (stat_q[g] && !(clr_wr && i_wdata[g]));
      end
    end
  end

  // Interrupt enable register
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      en_q <= '0;
    end else if (i_wr && (i_addr == ADDR_W'(`LEDC_INT_EN))) begin
      en_q <= i_wdata[`LEDC_IRQ_N-1:0];
    end
  end
  assign o_irq = |(stat_q & en_q);

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      if (i_addr <= ADDR_W'(`LEDC_CFG_TOP)) begin
        o_rdata <= cfg_q[int'(chunk)*`LEDC_CHUNK_BITS +: `LEDC_CHUNK_BITS];
      end else if (i_addr == ADDR_W'(`LEDC_INT_STAT)) begin
        o_rdata <= DATA_W'(stat_q);
      end else if (i_addr == ADDR_W'(`LEDC_INT_EN)) begin
        o_rdata <= DATA_W'(en_q);
      end else if (i_addr == ADDR_W'(`LEDC_STATE)) begin
        o_rdata <= DATA_W'({o_readback_sel, err_q, o_negate_check_bit});
      end else begin
        o_rdata <= '0;
      end
    end else begin
      o_rdata <= '0;
    end
  end

  // Checks; the sink bit lives in a lower chunk, so it is taken from staging
  sequence s_cmd(logic [11:0] code);
    commit_q && (cmd == code);
  endsequence
  sequence s_top_write;
    wr_top ##1 commit_q;
  endsequence
  property p_selftest;
    @(posedge i_clk) disable iff (!i_rstn)
      s_cmd(`LEDC_CMD_SELFTST) |=> o_selftest_start && !o_aps_start;
  endproperty
  a_selftest: assert property (p_selftest) else $error("self-test pulse missing");  // [RULE1]
  property p_glb_reset;
    @(posedge i_clk) disable iff (!i_rstn)
      s_cmd(`LEDC_CMD_GLB_RST) |=> o_global_reset && o_cfg.led_fault_mask
        && (o_readback_sel == LEDC_RB_NONE) && !o_negate_check_bit;
  endproperty
  a_glb_reset: assert property (p_glb_reset) else $error("global reset incomplete");  // [RULE1]
  property p_readback;
    @(posedge i_clk) disable iff (!i_rstn)
      s_cmd(`LEDC_CMD_RD_CFG) |=> (o_readback_sel == LEDC_RB_CFG);
  endproperty
  a_readback: assert property (p_readback) else $error("readback select wrong");  // [RULE2]
  property p_negate;
    @(posedge i_clk) disable iff (!i_rstn)
      s_cmd(`LEDC_CMD_NEGATE) |=> (o_negate_check_bit != $past(o_negate_check_bit));
  endproperty
  a_negate: assert property (p_negate) else $error("negate bit did not toggle");  // [RULE3]
  property p_err_clear;
    @(posedge i_clk) disable iff (!i_rstn)
      s_cmd(`LEDC_CMD_ERR_CLR) ##0 (!err_set && !wr_top)
        |=> !o_led_error_flag && o_error_clear ##1 !o_error_clear;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error not cleared");  // [RULE3]
  property p_mask;
    @(posedge i_clk) disable iff (!i_rstn)
      o_cfg.led_fault_mask && !o_led_error_flag && !commit_q |=> !o_led_error_flag;
  endproperty
  a_mask: assert property (p_mask) else $error("masked error was latched");  // [RULE4]
  property p_sink;
    @(posedge i_clk) disable iff (!i_rstn)
      wr_top && !hit_glb |=> o_cfg.adjacent_pin_test_sink == $past(stage_q[`LEDC_SINK_BIT]);
  endproperty
  a_sink: assert property (p_sink) else $error("sink bit not taken");  // [RULE5]
  property p_no_early;
    @(posedge i_clk) disable iff (!i_rstn)
      !wr_top |=> !commit_q ##1 !o_selftest_start && !o_aps_start && !o_global_reset;
  endproperty
  a_no_early: assert property (p_no_early) else $error("command acted early");  // [RULE6]
  property p_commit;
    @(posedge i_clk) disable iff (!i_rstn)
      s_top_write |-> (cmd == $past(i_wdata[`LEDC_CMD_MSB-TOP_BASE:`LEDC_CMD_LSB-TOP_BASE]));
  endproperty
  a_commit: assert property (p_commit) else $error("command field not latched");  // [RULE6]
  property p_gs_width;
    @(posedge i_clk) disable iff (!i_rstn)
      (cfg_q[`LEDC_GSW_MSB:`LEDC_GSW_LSB] == `LEDC_GSW_SEL8)
        |-> (o_cfg.grayscale_counter_width == `LEDC_GSW_8);
  endproperty
  a_gs_width: assert property (p_gs_width) else $error("counter width wrong");  // [RULE7]
  property p_bright;
    @(posedge i_clk) disable iff (!i_rstn)
      wr_top && !hit_glb |=> o_cfg.red_group_brightness == $past(stage_q[`LEDC_BR_R_MSB:`LEDC_BR_R_LSB])
        && o_cfg.blue_correction_range == $past(stage_q[`LEDC_RNG_B_BIT]);
  endproperty
  a_bright: assert property (p_bright) else $error("group field misplaced");  // [RULE8] [RULE9]

endmodule // ledc_config_regs

/* File: hdl/ledc_consts.svh */
`ifndef LEDC_CONSTS_SVH
`define LEDC_CONSTS_SVH

// Register map, 32-bit words at 8-bit addresses
`define LEDC_CFG_W0      8'h00
`define LEDC_CFG_TOP     8'h08
`define LEDC_INT_STAT    8'h10
`define LEDC_INT_CLR     8'h11
`define LEDC_INT_EN      8'h12
`define LEDC_STATE       8'h13

// Configuration word layout
`define LEDC_CFG_BITS    288
`define LEDC_CHUNK_BITS  32
`define LEDC_CMD_MSB     287
`define LEDC_CMD_LSB     276
`define LEDC_MASK_BIT    204
`define LEDC_SINK_BIT    200
`define LEDC_GSW_MSB     198
`define LEDC_GSW_LSB     197
`define LEDC_RNG_B_BIT   194
`define LEDC_RNG_G_BIT   193
`define LEDC_RNG_R_BIT   192
`define LEDC_BR_B_MSB    191
`define LEDC_BR_B_LSB    184
`define LEDC_BR_G_MSB    183
`define LEDC_BR_G_LSB    176
`define LEDC_BR_R_MSB    175
`define LEDC_BR_R_LSB    168

// Command codes
`define LEDC_CMD_GLB_RST 12'h25c
`define LEDC_CMD_SELFTST 12'h535
`define LEDC_CMD_APS     12'h53a
`define LEDC_CMD_NEGATE  12'h55a
`define LEDC_CMD_RD_STAT 12'h5a3
`define LEDC_CMD_RD_CFG  12'h5ac
`define LEDC_CMD_RD_GS   12'h5af
`define LEDC_CMD_ERR_CLR 12'ha53

// Counter widths chosen by the grayscale width field
`define LEDC_GSW_12      4'hc
`define LEDC_GSW_10      4'ha
`define LEDC_GSW_8       4'h8
`define LEDC_GSW_SEL10   2'h2
`define LEDC_GSW_SEL8    2'h3

// Interrupt status bit positions
`define LEDC_IRQ_N       7
`define LEDC_EV_COMMIT   0
`define LEDC_EV_SELFTST  1
`define LEDC_EV_APS      2
`define LEDC_EV_GLB_RST  3
`define LEDC_EV_NEGATE   4
`define LEDC_EV_ERR_CLR  5
`define LEDC_EV_LED_ERR  6

`endif

/* File: hdl/ledc_pkg.sv */
package ledc_pkg;

  // What the serial path shifts back out next
  typedef enum logic [3:0] {
    LEDC_RB_NONE = 4'h1,
    LEDC_RB_STAT = 4'h2,
    LEDC_RB_CFG  = 4'h4,
    LEDC_RB_GS   = 4'h8
  } ledc_rb_sel_t;

  // Decoded settings handed to the output stage
  typedef struct packed {
    logic [7:0] blue_group_brightness;
    logic [7:0] green_group_brightness;
    logic [7:0] red_group_brightness;
    logic       blue_correction_range;
    logic       green_correction_range;
    logic       red_correction_range;
    logic [3:0] grayscale_counter_width;
    logic       led_fault_mask;
    logic       adjacent_pin_test_sink;
  } ledc_cfg_t;

endpackage

/* File: testbench/ledc_config_regs_tb.sv */
`timescale 1ns/1ps
`include "ledc_consts.svh"

module ledc_config_regs_tb
  import ledc_pkg::*;
;

  // Command row: code, expected {reset, selftest, aps, clear} pulses, readback
  typedef struct {
    logic [11:0]  code;
    logic [3:0]   pulses;
    ledc_rb_sel_t rb;
  } ledc_row_t;

  logic         clk;
  logic         rstn;
  logic [7:0]   addr;
  logic [31:0]  wdata;
  logic [31:0]  rdata;
  logic         wr;
  logic         rd;
  logic         led_err;
  logic         glb;
  logic         self_t;
  logic         adjacent_pin_short_check;
  logic         clr;
  logic         neg;
  logic         eflag;
  logic         irq;
  ledc_rb_sel_t rb;
  ledc_cfg_t    cfg;
  ledc_cfg_t    e;
  logic [31:0]  rv;
  logic [3:0]   seen;
  int           err_total = 0;
  int           checked = 0;
  // Readback holds across other codes except global reset, which returns it to none; unknown code does nothing
  ledc_row_t    rows[8] = '{
    '{12'h5a3, 4'h0, LEDC_RB_STAT}, '{12'h535, 4'h4, LEDC_RB_STAT},
    '{12'h5ac, 4'h0, LEDC_RB_CFG},  '{12'h53a, 4'h2, LEDC_RB_CFG},
    '{12'h5af, 4'h0, LEDC_RB_GS},   '{12'ha53, 4'h1, LEDC_RB_GS},
    '{12'h123, 4'h0, LEDC_RB_GS},   '{12'h25c, 4'h8, LEDC_RB_NONE}};

  ledc_config_regs dut (
    .i_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_led_error(led_err), .o_global_reset(glb),
    .o_selftest_start(self_t), .o_aps_start(adjacent_pin_short_check), .o_error_clear(clr),
    .o_negate_check_bit(neg), .o_readback_sel(rb), .o_led_error_flag(eflag),
    .o_cfg(cfg), .o_irq(irq));

  ledc_host_model u_host (
    .i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
    .i_rdata(rdata), .o_led_error(led_err));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Command in the top twelve bits; pulses gathered over the following edges
  task automatic cmd(input logic [11:0] c);
    u_host.wr(`LEDC_CFG_TOP, {c, 20'h00000});
    seen = 4'h0;
    repeat (3) begin
      @(posedge clk);
      #1 seen = seen | {glb, self_t, adjacent_pin_short_check, clr};
    end
  endtask

  task automatic complete_run();
    $display("errors %0d, comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog at 20000 cycles, far beyond the couple of hundred cycles the tests need
  initial begin
    #100000;
    err_total++;
    complete_run();
  end

  initial begin
    rstn = 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    e = '0;
    e.grayscale_counter_width = `LEDC_GSW_12;
    e.led_fault_mask = 1'b1;
    #1 chk("cfg", 64'(e), 64'(cfg));
    chk("rb", 64'(LEDC_RB_NONE), 64'(rb));
    chk("neg irq", 64'h0, 64'({neg, irq}));
    u_host.rd(8'h06, rv);
    chk("chunk6", 64'h1000, 64'(rv));
    // Masked fault must not latch
    u_host.err_pulse();
    repeat (2) @(posedge clk);
    #1 chk("eflag", 64'h0, 64'(eflag));
    // Every listed code and one unknown code
    foreach (rows[i]) begin
      cmd(rows[i].code);
      chk("pulses", 64'(rows[i].pulses), 64'(seen));
      chk("rb", 64'(rows[i].rb), 64'(rb));
    end
    chk("cfg", 64'(e), 64'(cfg));
    cmd(12'h55a);
    chk("neg", 64'h1, 64'(neg));
    cmd(12'h55a);
    chk("neg", 64'h0, 64'(neg));
    // Staged chunks stay invisible until the top chunk commits
    u_host.wr(8'h05, 32'hc35a_9600);
    u_host.wr(8'h06, 32'h0000_0147);
    repeat (3) @(posedge clk);
    #1 chk("staged", 64'(e), 64'(cfg));
    cmd(12'h000);
    e = '{8'hc3, 8'h5a, 8'h96, 1'b1, 1'b1, 1'b1, `LEDC_GSW_10, 1'b0, 1'b1};
    chk("cfg", 64'(e), 64'(cfg));
    u_host.rd(8'h06, rv);
    chk("chunk6", 64'h147, 64'(rv));
    u_host.wr(8'h06, 32'h0000_0060);
    cmd(12'h000);
    chk("width", 64'(`LEDC_GSW_8), 64'(cfg.grayscale_counter_width));
    // Unmasked fault latches, clear code drops it
    u_host.err_pulse();
    repeat (2) @(posedge clk);
    #1 chk("eflag", 64'h1, 64'(eflag));
    cmd(12'ha53);
    chk("eflag", 64'h0, 64'(eflag));
    // A new fault in the very cycle of the clear code must win
    fork
      cmd(12'ha53);
      begin
        @(posedge clk);
        u_host.err_pulse();
      end
    join
    chk("eflag set wins", 64'h1, 64'(eflag));
    // Interrupt: clear all, enable commit, raise, clear
    u_host.wr(`LEDC_INT_CLR, 32'h0000_007f);
    u_host.wr(`LEDC_INT_EN, 32'h0000_0001);
    u_host.rd(`LEDC_INT_STAT, rv);
    chk("stat", 64'h0, 64'(rv));
    cmd(12'h000);
    chk("irq", 64'h1, 64'(irq));
    u_host.rd(`LEDC_INT_STAT, rv);
    chk("stat", 64'h1, 64'(rv));
    u_host.wr(`LEDC_INT_CLR, 32'h0000_0001);
    @(posedge clk);
    #1 chk("irq", 64'h0, 64'(irq));
    u_host.rd(`LEDC_INT_EN, rv);
    chk("en", 64'h1, 64'(rv));
    u_host.rd(8'h20, rv);
    chk("unmapped", 64'h0, 64'(rv));
    // State word: readback none, error latched, negate low
    u_host.rd(`LEDC_STATE, rv);
    chk("state", 64'h6, 64'(rv));
    @(posedge clk);
    #1 chk("rdata idle", 64'h0, 64'(rdata));
    // Reset in mid-run brings every setting and flag back
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    e = '0;
    e.grayscale_counter_width = `LEDC_GSW_12;
    e.led_fault_mask = 1'b1;
    #1 chk("cfg rst", 64'(e), 64'(cfg));
    chk("flags rst", 64'h0, 64'({neg, eflag, irq}));
    chk("rb rst", 64'(LEDC_RB_NONE), 64'(rb));
    u_host.rd(`LEDC_INT_EN, rv);
    chk("en rst", 64'h0, 64'(rv));
    complete_run();
  end
endmodule // ledc_config_regs_tb

/* File: testbench/ledc_host_model.sv */
`timescale 1ns/1ps

// Host side of the register port; one access at a time, strobes one cycle long
module ledc_host_model (
  // Clock
  input  wire logic        i_clk,
  // Register port toward the device
  output logic      [7:0]  o_addr,
  output logic      [31:0] o_wdata,
  output logic             o_wr,
  output logic             o_rd,
  input  wire logic [31:0] i_rdata,
  // Fault event toward the device
  output logic             o_led_error
);
  // Idle values from time zero
  initial begin
    o_addr      = 8'h00;
    o_wdata     = 32'h0000_0000;
    o_wr        = 1'b0;
    o_rd        = 1'b0;
    o_led_error = 1'b0;
  end

  // Write; data is inverted after release so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_wr    <= 1'b1;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_wdata <= ~d;
  endtask

  // Read; data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    o_rd   <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    #1 d = i_rdata;
  endtask

  // One-cycle fault event
  task automatic err_pulse();
    @(posedge i_clk);
    o_led_error <= 1'b1;
    @(posedge i_clk);
    o_led_error <= 1'b0;
  endtask
endmodule // ledc_host_model
